// >>> ifd_pkg.sv
// Package for the instruction field decoder: field positions, formats, stages
// Assumes a 14-bit instruction word and a four-phase instruction cycle.
package ifd_pkg;

   localparam int IW = 14;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   // Phases of one instruction cycle, named by the step that their closing edge enters;
   // the word is taken at phase 0 and reaches the decode one edge later
   localparam int PHASES = 4;
   localparam logic [1:0] PH_READ = 2'h2;
   localparam logic [1:0] PH_MOD = 2'h3;
   localparam logic [1:0] PH_WRITE = 2'h0;
   // Field positions
   localparam int DEST_BIT = 7;
   localparam int BIT_LSB = 7;
   localparam int PTR_SEL_BIT = 6;
   localparam int MODE_PTR_BIT = 2;
   localparam logic [6:0] FILE_MAX = 7'h7f;
   localparam logic [6:0] INDIRECT_PORT0 = 7'h00;
   localparam logic [6:0] INDIRECT_PORT1 = 7'h01;

   typedef enum logic [3:0]
   {
      FMT_OPONLY = 4'h0,
      FMT_BYTE = 4'h1,
      FMT_BIT = 4'h2,
      FMT_LIT8 = 4'h3,
      FMT_JUMP = 4'h4,
      FMT_PAGE = 4'h5,
      FMT_BANK = 4'h6,
      FMT_BRANCH = 4'h7,
      FMT_PTR_OFS = 4'h8,
      FMT_PTR_UPD = 4'h9
   } ifd_fmt_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_READ = 2'h1,
      ST_MOD = 2'h2,
      ST_WRITE = 2'h3
   } ifd_state_t;

   typedef struct packed
   {
      ifd_fmt_t fmt;
      logic [13:0] opcode;
      logic dest_file;
      logic [6:0] file_addr;
      logic [2:0] bit_idx;
      logic [10:0] literal;
      logic ptr_sel;
      logic [1:0] pointer_update_mode;
      logic uses_file;
   } ifd_fields_t;

   typedef struct packed
   {
      logic file_rd;
      logic file_wr;
      logic w_wr;
      logic [6:0] addr;
   } ifd_ctrl_t;

endpackage

// >>> ifd_word_reg.sv
`timescale 1ns/1ps
// Small store for the word being executed and its predecessor
// Assumes a single clock; read data comes from a register.
module ifd_word_reg
   import ifd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [13:0] wdata_i,
   output logic [13:0] rdata_o,
   output logic [13:0] prev_o
);
   logic [13:0] mem_ff [0:1];
   logic [13:0] rdata_ff;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_ff[0] <= NOP_WORD;
         mem_ff[1] <= NOP_WORD;
      end
      else if (wr_i)
      begin
         mem_ff[1] <= mem_ff[0];
         mem_ff[0] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_ff <= NOP_WORD;
      else
         rdata_ff <= mem_ff[0];
   end

   assign rdata_o = rdata_ff;
   assign prev_o = mem_ff[1];
endmodule // ifd_word_reg

// >>> ifd_decoder.sv
`timescale 1ns/1ps
// Instruction field decoder: splits 14-bit words into operand fields and
// sequences the read-modify-write of file-register instructions.
// Assumes fetch presents one word per instruction cycle with instr_valid_i.
//
// How it works
// - File instructions run read, modify, write back
// - Read happens even for write-only instructions
// - Destination bit 0 picks W, 1 file
// - File address spans 0x00 to 0x7F
// - Byte ops: opcode 13:8, d 7, f 6:0
// - Bit ops: 3-bit bit index, 7-bit file
// - Literal ops: opcode 13:8, 8-bit literal
// - Call/jump: opcode 13:11, 11-bit target
// - Page latch load: opcode 13:7, 7-bit literal
// - Bank load: opcode 13:5, 5-bit literal
// - Relative branch: opcode 13:9, 9-bit offset
// - Pointer offset: pointer select, 6-bit offset
// - Pointer update: select bit 2, mode 1:0
// - Pointer select picks pointer zero or one
// - Don't-care bits never change decoding
// - One 14-bit word holds opcode and operands
// - One instruction cycle is four clocks
module ifd_decoder
   import ifd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire logic [13:0] instr_i,
   output ifd_fields_t fields_o,
   output ifd_ctrl_t ctrl_o,
   output logic cycle_start_o,
   output logic busy_o
);

   // Classify a word into its format; don't-care bits are never inspected
   function automatic ifd_fmt_t classify(input logic [13:0] w);
      ifd_fmt_t f;
      f = FMT_OPONLY;
      case (w[13:12])
         2'h0:
         begin
            if (w[11:8] != 4'h0)
               f = FMT_BYTE;
            else if (w[7])
               f = FMT_BYTE;
            else if (w[6:5] == 2'h1)
               f = FMT_BANK;
            else if (w[6:3] == 4'h2)
               f = FMT_PTR_UPD;
            else if (w[6:2] != 5'h00 || w[1:0] == 2'h3)
               f = FMT_OPONLY;
            else if (w[6:0] == 7'h03)
               f = FMT_BYTE;
            else
               f = FMT_OPONLY;
         end
         2'h1: f = FMT_BIT;
         2'h2: f = FMT_JUMP;
         default:
         begin
            if (w[11:9] == 3'h1)
               f = FMT_BRANCH;
            else if (w[11:8] == 4'h1)
               f = w[7] ? FMT_PAGE : FMT_PTR_OFS;
            else
               f = FMT_LIT8;
         end
      endcase
      return f;
   endfunction

   // Split a word by format into fields
   function automatic ifd_fields_t split(input logic [13:0] w);
      ifd_fields_t r;
      r = '0;
      r.fmt = classify(w);
      case (r.fmt)
         FMT_BYTE:
         begin
            r.opcode = {8'h00, w[13:8]};
            r.dest_file = w[DEST_BIT];
            r.file_addr = w[6:0] & FILE_MAX;
            // Clear-W ignores its two low bits, so they must not leak into the address
            if (w[13:7] == 7'h02)
               r.file_addr[1:0] = 2'h0;
            r.uses_file = (w[13:8] != 6'h00) || w[DEST_BIT];
         end
         FMT_BIT:
         begin
            r.opcode = {10'h000, w[13:10]};
            r.bit_idx = w[9:BIT_LSB];
            r.file_addr = w[6:0];
            r.dest_file = 1'b1;
            r.uses_file = 1'b1;
         end
         FMT_LIT8:
         begin
            r.opcode = {8'h00, w[13:8]};
            r.literal = {3'h0, w[7:0]};
         end
         FMT_JUMP:
         begin
            r.opcode = {11'h000, w[13:11]};
            r.literal = w[10:0];
         end
         FMT_PAGE:
         begin
            r.opcode = {7'h00, w[13:7]};
            r.literal = {4'h0, w[6:0]};
         end
         FMT_BANK:
         begin
            r.opcode = {5'h00, w[13:5]};
            r.literal = {6'h00, w[4:0]};
         end
         FMT_BRANCH:
         begin
            r.opcode = {9'h000, w[13:9]};
            r.literal = {2'h0, w[8:0]};
         end
         FMT_PTR_OFS:
         begin
            r.opcode = {7'h00, w[13:7]};
            r.ptr_sel = w[PTR_SEL_BIT];
            r.literal = {5'h00, w[5:0]};
         end
         FMT_PTR_UPD:
         begin
            r.opcode = {3'h0, w[13:3]};
            r.ptr_sel = w[MODE_PTR_BIT];
            r.pointer_update_mode = w[1:0];
         end
         default:
            r.opcode = w;
      endcase
      return r;
   endfunction

   logic [13:0] word_q;
   ifd_fields_t dec;
   ifd_state_t state_ff;
   ifd_state_t nxt_state;
   logic [1:0] phase_ff;
   logic taken_ff;
   logic load_ff;
   logic start_ff;
   ifd_fields_t fields_ff;
   ifd_ctrl_t ctrl_ff;
   ifd_ctrl_t nxt_ctrl;

   // Whole 14-bit word is held; load accepted once per instruction cycle
   ifd_word_reg u_word
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .wr_i(instr_valid_i && phase_ff == 2'h0),
      .wdata_i(instr_i),
      .rdata_o(word_q),
      .prev_o()
   );

   assign dec = split(word_q);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         phase_ff <= 2'h0;
      else
         phase_ff <= phase_ff + 2'h1;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         taken_ff <= 1'b0;
         load_ff <= 1'b0;
         start_ff <= 1'b0;
      end
      else
      begin
         // The word reaches word_q one edge after it is taken; decode waits for it
         taken_ff <= instr_valid_i && phase_ff == 2'h0;
         load_ff <= taken_ff;
         start_ff <= phase_ff == 2'h0;
      end
   end

   always_comb
   begin
      case (phase_ff)
         PH_READ: nxt_state = (load_ff && dec.uses_file) ? ST_READ : ST_IDLE;
         PH_MOD: nxt_state = (state_ff == ST_READ) ? ST_MOD : ST_IDLE;
         PH_WRITE: nxt_state = (state_ff == ST_MOD) ? ST_WRITE : ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   always_comb
   begin
      nxt_ctrl = '0;
      // Read leaves at the edge that captures the fields, so it takes the fresh decode
      nxt_ctrl.addr = load_ff ? dec.file_addr : fields_ff.file_addr;
      case (nxt_state)
         ST_READ: nxt_ctrl.file_rd = 1'b1;
         ST_WRITE:
         begin
            nxt_ctrl.file_wr = fields_ff.dest_file;
            nxt_ctrl.w_wr = !fields_ff.dest_file;
         end
         ST_IDLE, ST_MOD: nxt_ctrl.file_rd = 1'b0;
         default: nxt_ctrl = '0;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         fields_ff <= '0;
      else if (load_ff)
         fields_ff <= dec;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_ff <= '0;
      else
         ctrl_ff <= nxt_ctrl;
   end

   // Fields stand from the read edge until the next word is decoded
   assign fields_o = fields_ff;
   assign ctrl_o = ctrl_ff;
   assign cycle_start_o = start_ff;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         busy_o <= 1'b0;
      else
         busy_o <= nxt_state != ST_IDLE;
   end

   rd_before_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.file_rd |-> ##2 (ctrl_o.file_wr || ctrl_o.w_wr))
      else $error("read not followed by write-back");
   wr_after_rd_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ctrl_o.file_wr || ctrl_o.w_wr) |-> $past(ctrl_o.file_rd, 2))
      else $error("write-back without prior read");
   dest_route_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      !(ctrl_o.file_wr && ctrl_o.w_wr))
      else $error("result routed to both W and file");
   addr_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.file_rd |-> ctrl_o.addr == fields_o.file_addr)
      else $error("read address differs from decoded file address");
   busy_span_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.file_rd |-> busy_o ##1 busy_o ##1 busy_o)
      else $error("busy dropped inside read-modify-write");
   page_lit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_PAGE |-> dec.literal[6:0] == word_q[6:0])
      else $error("page latch literal misdecoded");
   bank_lit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_BANK |-> dec.literal[4:0] == word_q[4:0])
      else $error("bank literal misdecoded");
   branch_lit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_BRANCH |-> dec.literal[8:0] == word_q[8:0])
      else $error("branch offset misdecoded");
   ptr_ofs_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_PTR_OFS |-> dec.literal[5:0] == word_q[5:0] && dec.ptr_sel == word_q[6])
      else $error("pointer offset misdecoded");
   phase_wrap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      cycle_start_o |-> ##4 cycle_start_o)
      else $error("instruction cycle not four clocks");
   jump_lit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_JUMP |-> dec.literal == word_q[10:0])
      else $error("jump target misdecoded");
   bit_idx_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_BIT |-> dec.bit_idx == word_q[9:7] && dec.uses_file)
      else $error("bit index misdecoded");
   ptr_mode_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_PTR_UPD |-> dec.pointer_update_mode == word_q[1:0])
      else $error("pointer mode misdecoded");
   byte_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      dec.fmt == FMT_BYTE |-> dec.opcode[5:0] == word_q[13:8])
      else $error("byte opcode misdecoded");
   rmw_c: cover property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.file_rd ##2 ctrl_o.file_wr);
   w_dest_c: cover property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.file_rd ##2 ctrl_o.w_wr);
   branch_c: cover property (@(posedge mclk_i) disable iff (rst_i) dec.fmt == FMT_BRANCH);
   bit_op_c: cover property (@(posedge mclk_i) disable iff (rst_i) dec.fmt == FMT_BIT);
   ptr_upd_c: cover property (@(posedge mclk_i) disable iff (rst_i) dec.fmt == FMT_PTR_UPD);
endmodule // ifd_decoder

// >>> ifd_core_model.sv
`timescale 1ns/1ps
// Model of the core datapath: counts the file and W strobes of the decoder.
// Assumes strobes are one-cycle pulses on mclk_i; clear_i starts a new count.
module ifd_core_model
   import ifd_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire ifd_ctrl_t ctrl_i,
   output logic [3:0] rd_cnt_o,
   output logic [3:0] fwr_cnt_o,
   output logic [3:0] wwr_cnt_o,
   output logic [6:0] addr_o,
   output logic err_o
);
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_cnt_o <= 4'h0;
         fwr_cnt_o <= 4'h0;
         wwr_cnt_o <= 4'h0;
         addr_o <= 7'h00;
         err_o <= 1'b0;
      end
      else if (clear_i)
      begin
         rd_cnt_o <= 4'h0;
         fwr_cnt_o <= 4'h0;
         wwr_cnt_o <= 4'h0;
         addr_o <= 7'h00;
         err_o <= 1'b0;
      end
      else
      begin
         if (ctrl_i.file_rd)
         begin
            rd_cnt_o <= rd_cnt_o + 4'h1;
            addr_o <= ctrl_i.addr;
         end
         if (ctrl_i.file_wr)
            fwr_cnt_o <= fwr_cnt_o + 4'h1;
         if (ctrl_i.w_wr)
            wwr_cnt_o <= wwr_cnt_o + 4'h1;
         // A write with no read before it, or a file write to another place, breaks the sequence
         if ((ctrl_i.file_wr || ctrl_i.w_wr) && rd_cnt_o == 4'h0)
            err_o <= 1'b1;
         if (ctrl_i.file_wr && ctrl_i.addr != addr_o)
            err_o <= 1'b1;
      end
   end
endmodule // ifd_core_model

// >>> instruction_field_decoder_bench.sv
`timescale 1ns/1ps
// Bench for the decoder: offers words as fetch would and judges fields and strobes.
// Assumes words are taken only at phase 0 and fields stand until the next word.
module instruction_field_decoder_bench;
   import ifd_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic vld = 1'b0;
   logic [13:0] word = 14'h0000;
   logic clr = 1'b0;
   ifd_fields_t fld;
   ifd_fields_t s;
   ifd_ctrl_t ctl;
   logic cstart;
   logic busy;
   logic [3:0] n_rd;
   logic [3:0] n_fw;
   logic [3:0] n_ww;
   logic [6:0] m_addr;
   logic m_err;
   int failures = 0;
   int num_checks = 0;
   int n_busy = 0;

   initial forever #2.5 mclk_i = ~mclk_i;

   ifd_decoder uut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(vld), .instr_i(word),
      .fields_o(fld), .ctrl_o(ctl), .cycle_start_o(cstart), .busy_o(busy));
   ifd_core_model core (.mclk_i(mclk_i), .rst_i(rst_i), .clear_i(clr), .ctrl_i(ctl),
      .rd_cnt_o(n_rd), .fwr_cnt_o(n_fw), .wwr_cnt_o(n_ww), .addr_o(m_addr), .err_o(m_err));

   // Busy cycles seen since the current word was offered
   always @(negedge mclk_i)
   begin
      if (busy === 1'b1)
         n_busy++;
   end

   task give_verdict;
   begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   task chk(input string what, input logic [13:0] exp, input logic [13:0] got);
   begin
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   end
   endtask

   // Held over four edges so exactly one phase-0 edge sees it
   task run_word(input logic [13:0] w);
   begin
      n_busy = 0;
      @(negedge mclk_i);
      clr <= 1'b1;
      vld <= 1'b1;
      word <= w;
      @(negedge mclk_i);
      clr <= 1'b0;
      repeat (3) @(negedge mclk_i);
      vld <= 1'b0;
      word <= ~w;
      repeat (8) @(negedge mclk_i);
   end
   endtask

   task chk_rmw(input logic [3:0] rd, input logic [3:0] fw, input logic [3:0] ww);
   begin
      chk("reads", {10'h0, rd}, {10'h0, n_rd});
      chk("file_writes", {10'h0, fw}, {10'h0, n_fw});
      chk("w_writes", {10'h0, ww}, {10'h0, n_ww});
      chk("sequence_err", 14'h0, {13'h0, m_err});
      chk("busy_cycles", (rd != 4'h0) ? 14'h3 : 14'h0, n_busy[13:0]);
   end
   endtask

   task chk_fl(input ifd_fmt_t f, input logic [13:0] lit, input logic [13:0] mask);
   begin
      chk("fmt", {10'h0, f}, {10'h0, fld.fmt});
      chk("literal", lit, {3'h0, fld.literal} & mask);
      chk_rmw(4'h0, 4'h0, 4'h0);
   end
   endtask

   task t_byte_ops;
   begin
      run_word(14'h07ff);
      chk("fmt", {10'h0, FMT_BYTE}, {10'h0, fld.fmt});
      chk("dest", 14'h1, {13'h0, fld.dest_file});
      chk("faddr", 14'h7f, {7'h0, fld.file_addr});
      chk_rmw(4'h1, 4'h1, 4'h0);
      chk("rd_addr", 14'h7f, {7'h0, m_addr});
      run_word(14'h0300);
      chk("dest", 14'h0, {13'h0, fld.dest_file});
      chk("faddr", 14'h00, {7'h0, fld.file_addr});
      chk_rmw(4'h1, 4'h0, 4'h1);
      run_word(14'h00a5);
      chk("faddr", 14'h25, {7'h0, fld.file_addr});
      chk_rmw(4'h1, 4'h1, 4'h0);
   end
   endtask

   task t_bit_op;
   begin
      run_word(14'h1692);
      chk("fmt", {10'h0, FMT_BIT}, {10'h0, fld.fmt});
      chk("bit", 14'h5, {11'h0, fld.bit_idx});
      chk("faddr", 14'h12, {7'h0, fld.file_addr});
      chk_rmw(4'h1, 4'h1, 4'h0);
   end
   endtask

   task t_literals;
   begin
      run_word(14'h30a5);
      chk_fl(FMT_LIT8, 14'h0a5, 14'h0ff);
      run_word(14'h2da3);
      chk_fl(FMT_JUMP, 14'h5a3, 14'h7ff);
      run_word(14'h2123);
      chk_fl(FMT_JUMP, 14'h123, 14'h7ff);
      run_word(14'h31ff);
      chk_fl(FMT_PAGE, 14'h07f, 14'h07f);
      run_word(14'h0035);
      chk_fl(FMT_BANK, 14'h015, 14'h01f);
      run_word(14'h33ff);
      chk_fl(FMT_BRANCH, 14'h1ff, 14'h1ff);
   end
   endtask

   task t_pointers;
   begin
      run_word(14'h316a);
      chk_fl(FMT_PTR_OFS, 14'h02a, 14'h03f);
      chk("ptr", 14'h1, {13'h0, fld.ptr_sel});
      run_word(14'h0016);
      chk("fmt", {10'h0, FMT_PTR_UPD}, {10'h0, fld.fmt});
      chk("ptr", 14'h1, {13'h0, fld.ptr_sel});
      chk("mode", 14'h2, {12'h0, fld.pointer_update_mode});
      run_word(14'h0011);
      chk("ptr", 14'h0, {13'h0, fld.ptr_sel});
      chk("mode", 14'h1, {12'h0, fld.pointer_update_mode});
   end
   endtask

   task t_opcode_only;
   begin
      run_word(14'h000b);
      chk("fmt", {10'h0, FMT_OPONLY}, {10'h0, fld.fmt});
      chk("opcode", 14'h000b, fld.opcode);
      chk_rmw(4'h0, 4'h0, 4'h0);
   end
   endtask

   // Don't-care bits set both ways must decode alike
   task t_dont_care;
   begin
      run_word(14'h0100);
      s = fld;
      run_word(14'h0103);
      chk("dc_same", 14'h0, {13'h0, fld !== s});
      chk_rmw(4'h1, 4'h0, 4'h1);
   end
   endtask

   // Reset in mid-run clears every output and restarts the phase count at once
   task t_reset;
   begin
      @(negedge mclk_i);
      rst_i <= 1'b1;
      @(negedge mclk_i);
      chk("rst_fields", 14'h0, {13'h0, |fld});
      chk("rst_ctrl", 14'h0, {13'h0, |ctl});
      chk("rst_start_busy", 14'h0, {12'h0, cstart, busy});
      rst_i <= 1'b0;
      @(negedge mclk_i);
      chk("first_start", 14'h1, {13'h0, cstart});
      run_word(14'h07ff);
      chk_rmw(4'h1, 4'h1, 4'h0);
   end
   endtask

   task t_cycle_len;
      int n;
   begin
      n = 0;
      while (cstart !== 1'b1 && n < 20)
      begin
         @(negedge mclk_i);
         n++;
      end
      n = 0;
      @(negedge mclk_i);
      while (cstart !== 1'b1 && n < 20)
      begin
         @(negedge mclk_i);
         n++;
      end
      chk("cycle_len", 14'h4, n[13:0] + 14'h1);
   end
   endtask

   initial
   begin
      repeat (16) @(negedge mclk_i);
      rst_i <= 1'b0;
      t_byte_ops();
      t_bit_op();
      t_literals();
      t_pointers();
      t_opcode_only();
      t_dont_care();
      t_reset();
      t_cycle_len();
      give_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge mclk_i);
      failures++;
      give_verdict();
   end
endmodule // instruction_field_decoder_bench
